// >>> hdl/line_alarm_event_status_irq.sv
// line alarm condition and frame event status registers with interrupt masks
`timescale 1ns/100ps

module line_alarm_event_status_irq (
    input wire logic clk, // 50 MHz system clock
    input wire logic sys_rst, // asynchronous reset, active high
    input wire logic clkEn, // freezes all state while low
    input wire line_alarm_pkg::host_req_type hostReq, // parallel port request
    output logic [7:0] hostRdData, // read data, valid the cycle after rdStrobe
    output logic intReqN, // interrupt request, active low level
    input wire line_alarm_pkg::framer_in_type framerIn, // framer conditions and strobes
    input wire logic rx_line_clock_in, // receive line clock pin
    input wire logic tx_clock_in, // transmit clock pin
    output logic alarmPinOut // shared alarm output pin
);

    // complete state of the block
    typedef struct packed {
        logic [7:0] condPrev; // last sampled condition vector
        logic [7:0] condPend; // latched condition edges awaiting read
        logic [7:0] mask3; // condition masks
        logic [7:0] events; // latched frame events
        logic [7:0] mask4; // event masks
        logic alarmPinSel; // alarm pin function select
        logic [7:0] rdData; // read data holding register
        logic [1:0] rxClkSync; // pin synchroniser, bit 0 first stage
        logic [1:0] txClkSync; // pin synchroniser, bit 0 first stage
        logic rxClkLast; // previous synchronised receive clock
        logic txClkLast; // previous synchronised transmit clock
        logic [line_alarm_pkg::LOSS_CNT_W-1:0] rxIdleCnt; // cycles since receive edge
        logic [line_alarm_pkg::LOSS_CNT_W-1:0] txIdleCnt; // cycles since transmit edge
        logic rxClockLoss; // receive clock loss level
        logic txClockLoss; // transmit clock loss level
        logic [1:0] distantMfCnt; // consecutive frame-0 alarm bits seen
        logic distantMfAlarm; // distant multiframe alarm level
        logic ts16AnyOne; // a one seen in timeslot 16 this multiframe
        logic ts16Started; // a multiframe boundary has been seen
        logic [3:0] onesFrameCnt; // frame index within 16-frame window
        logic [1:0] onesZeroCnt; // zeros seen in window, saturating
        logic intActive; // registered interrupt request
    } state_type;

    state_type stateReg; // registered state
    state_type stateNext; // next state

    // selects a register for the given address; unmapped reads give zero
    function automatic logic [7:0] readMux(input logic [7:0] addr, input state_type st,
                                           input logic [7:0] cond);
        begin
            case (addr)
                line_alarm_pkg::LINE_ALARM_STATUS_THREE_ADDR: readMux = cond;
                line_alarm_pkg::LINE_ALARM_MASK_THREE_ADDR: readMux = st.mask3;
                line_alarm_pkg::FRAME_EVENT_STATUS_FOUR_ADDR: readMux = st.events;
                line_alarm_pkg::FRAME_EVENT_MASK_FOUR_ADDR: readMux = st.mask4;
                line_alarm_pkg::COMMON_CONTROL_ONE_ADDR: begin
                    readMux = line_alarm_pkg::REG_RESET_VALUE;
                    readMux[line_alarm_pkg::ALARM_PIN_SEL_BIT] = st.alarmPinSel;
                end
                default: readMux = line_alarm_pkg::UNMAPPED_READ_VALUE;
            endcase
        end
    endfunction : readMux

    // counts zero bits of a timeslot byte, saturating at the alarm limit
    function automatic logic [1:0] addZeros(input logic [1:0] base, input logic [7:0] data);
        logic [1:0] acc;
        begin
            acc = base;
            for (int i = 0; i < 8; i++) begin
                if (!data[i] && acc != line_alarm_pkg::SIG_ONES_ZERO_LIMIT) begin
                    acc = acc + 2'h1;
                end
            end
            addZeros = acc;
        end
    endfunction : addZeros

    logic [7:0] condNow; // live condition vector
    logic [7:0] eventHits; // events raised this cycle
    logic [line_alarm_pkg::LOSS_CNT_W-1:0] channelCycles; // one channel time in cycles
    logic rxEdge; // transition seen on the receive clock pin
    logic txEdge; // transition seen on the transmit clock pin
    logic mfEnd; // a receive multiframe boundary closes the all-zeros check
    logic windowEnd; // last frame of the 16-frame all-ones window

    // live condition vector assembled from the framer and local detectors
    always_comb begin
        condNow = 8'h00;
        // E1-only conditions are held clear in T1 mode
        condNow[line_alarm_pkg::REMOTE_ALARM_BIT] =
            framerIn.e1Mode & framerIn.remoteAlarm;
        condNow[line_alarm_pkg::DISTANT_MF_ALARM_BIT] =
            framerIn.e1Mode & stateReg.distantMfAlarm;
        condNow[line_alarm_pkg::LINK_ID_BIT] =
            framerIn.e1Mode & framerIn.linkIdDetect;
        condNow[line_alarm_pkg::RX_CLOCK_LOSS_BIT] = stateReg.rxClockLoss;
        condNow[line_alarm_pkg::TX_CLOCK_LOSS_BIT] = stateReg.txClockLoss;
        // loop codes only count in T1 mode and follow the pattern level
        condNow[line_alarm_pkg::LOOP_UP_BIT] = !framerIn.e1Mode & framerIn.loopUpCode;
        condNow[line_alarm_pkg::LOOP_DOWN_BIT] = !framerIn.e1Mode & framerIn.loopDownCode;
        condNow[line_alarm_pkg::SPARE_CODE_BIT] = !framerIn.e1Mode & framerIn.spareCode;
    end

    // frame event strobes, gated by mode except the receive and transmit multiframe strobes
    always_comb begin
        mfEnd = framerIn.e1Mode & framerIn.rxMultiframe;
        windowEnd = framerIn.e1Mode & framerIn.ts16Strobe &
            (stateReg.onesFrameCnt == line_alarm_pkg::SIG_ONES_LAST_FRAME);
        eventHits = 8'h00;
        eventHits[line_alarm_pkg::RX_ALIGN_BIT] = framerIn.e1Mode & framerIn.rxAlignFrame;
        // the framer keeps a free 2 ms boundary running when CRC-4 is off
        eventHits[line_alarm_pkg::RX_CRC_MF_BIT] =
            framerIn.e1Mode & framerIn.rxCrcMultiframe;
        eventHits[line_alarm_pkg::RX_MF_BIT] = framerIn.rxMultiframe;
        eventHits[line_alarm_pkg::TX_ALIGN_BIT] = framerIn.e1Mode & framerIn.txAlignFrame;
        eventHits[line_alarm_pkg::TX_MF_BIT] = framerIn.txMultiframe;
        // all-zeros needs a full multiframe behind it, not a partial first one
        eventHits[line_alarm_pkg::SIG_ZEROS_BIT] =
            mfEnd & stateReg.ts16Started & !stateReg.ts16AnyOne;
        // fewer than three zeros over the window, counting the closing byte too
        eventHits[line_alarm_pkg::SIG_ONES_BIT] = windowEnd &
            (addZeros(stateReg.onesZeroCnt, framerIn.ts16Byte) !=
             line_alarm_pkg::SIG_ONES_ZERO_LIMIT);
        eventHits[line_alarm_pkg::AIS_CI_BIT] = !framerIn.e1Mode & framerIn.aisCiDetect;
    end

    // clock loss timing; channel time depends on the line rate
    always_comb begin
        channelCycles = framerIn.e1Mode ? line_alarm_pkg::E1_CHANNEL_CYCLES :
            line_alarm_pkg::T1_CHANNEL_CYCLES;
        rxEdge = stateReg.rxClkSync[1] ^ stateReg.rxClkLast;
        txEdge = stateReg.txClkSync[1] ^ stateReg.txClkLast;
    end

    // next-state logic for the whole block
    always_comb begin
        stateNext = stateReg;

        // pin synchronisers: only the second stage is read by logic
        stateNext.rxClkSync = {stateReg.rxClkSync[0], rx_line_clock_in};
        stateNext.txClkSync = {stateReg.txClkSync[0], tx_clock_in};
        stateNext.rxClkLast = stateReg.rxClkSync[1];
        stateNext.txClkLast = stateReg.txClkSync[1];

        // receive clock watchdog: loss set after one idle channel time, cleared on an edge
        if (rxEdge) begin
            stateNext.rxIdleCnt = '0;
            stateNext.rxClockLoss = 1'b0;
        end else if (stateReg.rxIdleCnt >= channelCycles) begin
            stateNext.rxClockLoss = 1'b1;
        end else begin
            stateNext.rxIdleCnt = stateReg.rxIdleCnt + 1'b1;
        end

        // transmit clock watchdog, same scheme
        if (txEdge) begin
            stateNext.txIdleCnt = '0;
            stateNext.txClockLoss = 1'b0;
        end else if (stateReg.txIdleCnt >= channelCycles) begin
            stateNext.txClockLoss = 1'b1;
        end else begin
            stateNext.txIdleCnt = stateReg.txIdleCnt + 1'b1;
        end

        // distant multiframe alarm: bit 6 of frame-0 timeslot 16, two in a row
        if (!framerIn.e1Mode) begin
            stateNext.distantMfCnt = 2'h0;
            stateNext.distantMfAlarm = 1'b0;
        end else if (framerIn.ts16Strobe && framerIn.ts16Frame0) begin
            if (framerIn.ts16Byte[line_alarm_pkg::TS16_ALARM_BIT]) begin
                // signaling mode does not gate this check
                if (stateReg.distantMfCnt != line_alarm_pkg::DISTANT_MF_REPEATS) begin
                    stateNext.distantMfCnt = stateReg.distantMfCnt + 2'h1;
                end
                stateNext.distantMfAlarm = (stateReg.distantMfCnt + 2'h1 >=
                    line_alarm_pkg::DISTANT_MF_REPEATS);
            end else begin
                stateNext.distantMfCnt = 2'h0;
                stateNext.distantMfAlarm = 1'b0;
            end
        end

        // timeslot 16 all-zeros tracking, restarted on each receive multiframe
        if (mfEnd) begin
            stateNext.ts16AnyOne = 1'b0;
            stateNext.ts16Started = 1'b1;
        end else if (framerIn.e1Mode && framerIn.ts16Strobe && framerIn.ts16Byte != 8'h00) begin
            stateNext.ts16AnyOne = 1'b1;
        end

        // timeslot 16 zero count over consecutive 16-frame windows
        if (framerIn.e1Mode && framerIn.ts16Strobe) begin
            if (windowEnd) begin
                stateNext.onesFrameCnt = 4'h0;
                stateNext.onesZeroCnt = 2'h0;
            end else begin
                stateNext.onesFrameCnt = stateReg.onesFrameCnt + 4'h1;
                stateNext.onesZeroCnt = addZeros(stateReg.onesZeroCnt, framerIn.ts16Byte);
            end
        end

        // read answer is registered; reading status three clears the pending edges, status four the events
        if (hostReq.rdStrobe) begin
            stateNext.rdData = readMux(hostReq.addr, stateReg, condNow);
            if (hostReq.addr == line_alarm_pkg::LINE_ALARM_STATUS_THREE_ADDR) begin
                stateNext.condPend = 8'h00;
            end
            if (hostReq.addr == line_alarm_pkg::FRAME_EVENT_STATUS_FOUR_ADDR) begin
                stateNext.events = 8'h00;
            end
        end

        // register writes; status registers are read-only and ignore writes
        if (hostReq.wrStrobe) begin
            case (hostReq.addr)
                line_alarm_pkg::LINE_ALARM_MASK_THREE_ADDR: stateNext.mask3 = hostReq.wrData;
                line_alarm_pkg::FRAME_EVENT_MASK_FOUR_ADDR: stateNext.mask4 = hostReq.wrData;
                line_alarm_pkg::COMMON_CONTROL_ONE_ADDR: begin
                    stateNext.alarmPinSel =
                        hostReq.wrData[line_alarm_pkg::ALARM_PIN_SEL_BIT];
                end
                default: begin
                    // unmapped or read-only: nothing changes
                end
            endcase
        end

        // either edge of a condition latches a pending interrupt; set beats the read clear
        stateNext.condPrev = condNow;
        stateNext.condPend = stateNext.condPend | (condNow ^ stateReg.condPrev);

        // events latch until the event register is read; set beats the read clear
        stateNext.events = stateNext.events | eventHits;

        // request stays up while any latched bit is unmasked
        stateNext.intActive = |(stateNext.condPend & stateNext.mask3) |
            |(stateNext.events & stateNext.mask4);
    end

    // state register; clock enable low freezes everything
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stateReg <= '0;
        end else if (clkEn) begin
            stateReg <= stateNext;
        end
    end

    // outputs driven from flip-flops except the alarm pin mux
    always_comb begin
        hostRdData = stateReg.rdData;
        intReqN = !stateReg.intActive;
        // pin shows loss of sync or transmit clock loss as selected
        alarmPinOut = stateReg.alarmPinSel ? stateReg.txClockLoss :
            framerIn.rxLossOfSync;
    end

endmodule : line_alarm_event_status_irq

// >>> hdl/line_alarm_pkg.sv
// constants and carrier types shared by the line alarm and frame event status block
package line_alarm_pkg;

    // register map of the parallel control port
    localparam logic [7:0] LINE_ALARM_STATUS_THREE_ADDR = 8'h1a; // condition flags
    localparam logic [7:0] LINE_ALARM_MASK_THREE_ADDR = 8'h1b; // condition masks
    localparam logic [7:0] FRAME_EVENT_STATUS_FOUR_ADDR = 8'h1c; // latched events
    localparam logic [7:0] FRAME_EVENT_MASK_FOUR_ADDR = 8'h1d; // event masks
    localparam logic [7:0] COMMON_CONTROL_ONE_ADDR = 8'h70; // common control
    localparam logic [7:0] REG_RESET_VALUE = 8'h00; // every register resets clear
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00; // answer to any other address

    // bit positions in the condition register
    localparam int REMOTE_ALARM_BIT = 0;
    localparam int DISTANT_MF_ALARM_BIT = 1;
    localparam int LINK_ID_BIT = 2;
    localparam int RX_CLOCK_LOSS_BIT = 3;
    localparam int TX_CLOCK_LOSS_BIT = 4;
    localparam int LOOP_UP_BIT = 5;
    localparam int LOOP_DOWN_BIT = 6;
    localparam int SPARE_CODE_BIT = 7;

    // bit positions in the event register
    localparam int RX_ALIGN_BIT = 0;
    localparam int RX_CRC_MF_BIT = 1;
    localparam int RX_MF_BIT = 2;
    localparam int TX_ALIGN_BIT = 3;
    localparam int TX_MF_BIT = 4;
    localparam int SIG_ZEROS_BIT = 5;
    localparam int SIG_ONES_BIT = 6;
    localparam int AIS_CI_BIT = 7;

    // common control field: alarm pin function select
    localparam int ALARM_PIN_SEL_BIT = 0;

    // distant multiframe alarm and signaling all-ones thresholds
    localparam logic [1:0] DISTANT_MF_REPEATS = 2'h2; // consecutive multiframes with bit set
    localparam int TS16_ALARM_BIT = 6; // bit 6 of timeslot 16 in frame 0
    localparam logic [3:0] SIG_ONES_LAST_FRAME = 4'hf; // 16 frames per window
    localparam logic [1:0] SIG_ONES_ZERO_LIMIT = 2'h3; // fewer than three zeros

    // one channel time (8 bit times) in each mode and the clock rate
    localparam int CLK_PERIOD_NS = 20; // 50 MHz system clock
    localparam int E1_CHANNEL_TIME_NS = 3906; // 8 bits at 2.048 Mb/s
    localparam int T1_CHANNEL_TIME_NS = 5181; // 8 bits at 1.544 Mb/s
    localparam int E1_CHANNEL_CYCLES_INT = (E1_CHANNEL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T1_CHANNEL_CYCLES_INT = (T1_CHANNEL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOSS_CNT_W = 9;
    localparam logic [LOSS_CNT_W-1:0] E1_CHANNEL_CYCLES = LOSS_CNT_W'(E1_CHANNEL_CYCLES_INT);
    localparam logic [LOSS_CNT_W-1:0] T1_CHANNEL_CYCLES = LOSS_CNT_W'(T1_CHANNEL_CYCLES_INT);

    // conditions and strobes delivered by the framer on the system clock
    typedef struct packed {
        logic e1Mode; // 1 = E1, 0 = T1
        logic rxLossOfSync; // receive loss of synchronization level
        logic remoteAlarm; // remote alarm detected level
        logic linkIdDetect; // link identification signal level
        logic loopUpCode; // loop-up pattern being received
        logic loopDownCode; // loop-down pattern being received
        logic spareCode; // spare pattern being received
        logic ts16Strobe; // pulse: timeslot 16 byte valid
        logic ts16Frame0; // that byte belongs to frame 0 of a multiframe
        logic [7:0] ts16Byte; // timeslot 16 content
        logic rxAlignFrame; // pulse: start of received align frame
        logic rxCrcMultiframe; // pulse: receive CRC-4 multiframe boundary
        logic rxMultiframe; // pulse: receive multiframe boundary
        logic txAlignFrame; // pulse: start of transmitted align frame
        logic txMultiframe; // pulse: transmit multiframe boundary
        logic aisCiDetect; // pulse: AIS-CI pattern detected
    } framer_in_type;

    // host side of the parallel control port
    typedef struct packed {
        logic [7:0] addr; // register address
        logic [7:0] wrData; // write data
        logic wrStrobe; // one-cycle write request
        logic rdStrobe; // one-cycle read request
    } host_req_type;

endpackage : line_alarm_pkg

// >>> verif/line_alarm_monitor.sv
// port checker for the line alarm and frame event status block
`timescale 1ns/100ps
module line_alarm_monitor (
    input wire logic clk, // system clock
    input wire logic sys_rst, // async reset
    input wire logic clkEn, // run enable
    input wire line_alarm_pkg::host_req_type hostReq, // host request
    input wire logic [7:0] hostRdData, // read data
    input wire logic intReqN, // interrupt, active low
    input wire line_alarm_pkg::framer_in_type framerIn, // framer inputs
    input wire logic rx_line_clock_in, // receive clock pin
    input wire logic tx_clock_in, // transmit clock pin
    input wire logic alarmPinOut // shared alarm pin
);
    logic [7:0] mask3Reg; // shadow of the condition masks
    logic [7:0] mask4Reg; // shadow of the event masks
    logic pinSelReg; // shadow of the alarm pin select
    logic [9:0] rxIdleReg; // enabled cycles since the receive pin moved
    logic [9:0] txIdleReg; // same for the transmit pin
    logic rxOldReg; // last receive pin level
    logic txOldReg; // last transmit pin level
    logic wrNow; // write taken at this edge
    logic quiet; // no framer pulse of any kind
    logic [7:0] evNow; // pulses that the mode lets latch
    assign wrNow = clkEn && hostReq.wrStrobe;
    // the six event pulses sit in bits 5:0 of the carrier
    assign quiet = !(|framerIn[5:0]) && !framerIn.ts16Strobe;
    assign evNow = {!framerIn.e1Mode && framerIn.aisCiDetect, 2'b00, framerIn.txMultiframe,
        framerIn.e1Mode && framerIn.txAlignFrame, framerIn.rxMultiframe,
        framerIn.e1Mode && framerIn.rxCrcMultiframe, framerIn.e1Mode && framerIn.rxAlignFrame};
    // shadows follow writes; idle counts saturate so a dead pin never looks alive again
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask3Reg <= 8'h00;
            mask4Reg <= 8'h00;
            pinSelReg <= 1'b0;
            rxIdleReg <= 10'h000;
            txIdleReg <= 10'h000;
            rxOldReg <= 1'b0;
            txOldReg <= 1'b0;
        end else begin
            if (wrNow && hostReq.addr == 8'h1b) mask3Reg <= hostReq.wrData;
            if (wrNow && hostReq.addr == 8'h1d) mask4Reg <= hostReq.wrData;
            if (wrNow && hostReq.addr == 8'h70) pinSelReg <= hostReq.wrData[0];
            rxOldReg <= rx_line_clock_in;
            txOldReg <= tx_clock_in;
            if (rx_line_clock_in != rxOldReg) rxIdleReg <= 10'h000;
            else if (clkEn && rxIdleReg != 10'h3ff) rxIdleReg <= rxIdleReg + 10'h001;
            if (tx_clock_in != txOldReg) txIdleReg <= 10'h000;
            else if (clkEn && txIdleReg != 10'h3ff) txIdleReg <= txIdleReg + 10'h001;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_rd(logic [7:0] a); clkEn && hostReq.rdStrobe && hostReq.addr == a; endsequence
    sequence s_rd4; clkEn && hostReq.rdStrobe && hostReq.addr == 8'h1c && quiet; endsequence
    property p_mask_rb; s_rd(8'h1b) |=> hostRdData == mask3Reg; endproperty
    a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");
    property p_clr_rd; s_rd4 ##1 quiet ##1 s_rd4 |=> hostRdData == 8'h00; endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("event kept after read");
    property p_ev_irq; clkEn && !wrNow && |(evNow & mask4Reg) |-> ##[1:2] !intReqN; endproperty
    a_ev_irq: assert property (p_ev_irq) else $error("event did not interrupt");
    property p_quiet; (clkEn && !wrNow && mask3Reg == 8'h00 && mask4Reg == 8'h00)[*2]
        |=> intReqN; endproperty
    a_quiet: assert property (p_quiet) else $error("masked source interrupted");
    property p_fall; $fell(framerIn.remoteAlarm) && framerIn.e1Mode && mask3Reg[0] && clkEn
        && $past(clkEn) && !wrNow |-> ##[1:2] !intReqN; endproperty
    a_fall: assert property (p_fall) else $error("falling edge missed");
    property p_loop; $rose(framerIn.loopUpCode) && !framerIn.e1Mode && mask3Reg[5] && clkEn
        && $past(clkEn) && !wrNow |-> ##[1:2] !intReqN; endproperty
    a_loop: assert property (p_loop) else $error("loop code edge missed");
    property p_rx_loss; clkEn && hostReq.rdStrobe && hostReq.addr == 8'h1a
        && rxIdleReg >= 10'd280 |=> hostRdData[3]; endproperty
    a_rx_loss: assert property (p_rx_loss) else $error("receive clock loss unseen");
    property p_tx_pin; pinSelReg && txIdleReg >= 10'd280 |-> alarmPinOut; endproperty
    a_tx_pin: assert property (p_tx_pin) else $error("alarm pin low on clock loss");
    property p_pin_sync; !pinSelReg |-> alarmPinOut == framerIn.rxLossOfSync; endproperty
    a_pin_sync: assert property (p_pin_sync) else $error("alarm pin not sync loss");
endmodule : line_alarm_monitor
bind line_alarm_event_status_irq line_alarm_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
    .clkEn(clkEn), .hostReq(hostReq), .hostRdData(hostRdData), .intReqN(intReqN),
    .framerIn(framerIn), .rx_line_clock_in(rx_line_clock_in), .tx_clock_in(tx_clock_in),
    .alarmPinOut(alarmPinOut));

// >>> verif/host_cpu_model.sv
// host processor model on the parallel control port
`timescale 1ns/100ps
module host_cpu_model (
    input wire logic clk, // system clock
    output line_alarm_pkg::host_req_type hostReq, // request to the port
    input wire logic [7:0] hostRdData // read data from the port
);
    // requests change after a falling edge and last exactly one cycle
    initial hostReq = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        hostReq = '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
        @(negedge clk);
        hostReq.wrStrobe = 1'b0;
    endtask : wr
    // status reads are how the host learns and clears what interrupted it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        hostReq = '{addr: a, wrData: 8'h00, wrStrobe: 1'b0, rdStrobe: 1'b1};
        @(negedge clk);
        hostReq.rdStrobe = 1'b0;
        d = hostRdData;
    endtask : rd
endmodule : host_cpu_model

// >>> verif/tb_top.sv
// self-checking bench for the line alarm and frame event status block
`timescale 1ns/100ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
    $display("Error %s expected %h seen %h", what, exp, got); end end
module tb_top;
    logic clk = 1'b0; // 50 MHz system clock
    logic sys_rst = 1'b1; // held for the first cycles
    logic clkEn = 1'b1; // run enable
    line_alarm_pkg::host_req_type hostReq; // from the host model
    line_alarm_pkg::framer_in_type framerIn = '0; // framer stimulus
    logic [7:0] hostRdData; // read data
    logic intReqN; // interrupt request
    logic alarmPinOut; // shared alarm pin
    logic rxPin = 1'b0; // receive line clock
    logic txPin = 1'b0; // transmit clock
    logic pinRun = 1'b1; // line clocks run while set
    logic [7:0] rdVal; // last read value
    logic [7:0] m4; // random event mask
    int num_errors = 0; // mismatches
    int n_compared = 0; // comparisons
    int expEv; // model of the latched events
    int regs[6] = '{'h1a, 'h1b, 'h1c, 'h1d, 'h70, 'h40}; // last one is unmapped
    int epos[6] = '{5, 4, 3, 2, 1, 0}; // carrier bit of each event pulse
    int ebit[6] = '{0, 1, 2, 3, 4, 7}; // status bit of each event pulse
    int cpos[5] = '{20, 19, 18, 17, 16}; // carrier bit of each condition level
    int cbit[5] = '{0, 2, 5, 6, 7}; // status bit of each condition
    bit ok; // condition allowed in this mode
    always #10 clk = ~clk;
    // line clocks near 2.048 and 1.544 MHz, not tied to clk
    always #244 if (pinRun) rxPin = ~rxPin;
    always #324 if (pinRun) txPin = ~txPin;
    line_alarm_event_status_irq DUT (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .hostReq(hostReq), .hostRdData(hostRdData), .intReqN(intReqN), .framerIn(framerIn),
        .rx_line_clock_in(rxPin), .tx_clock_in(txPin), .alarmPinOut(alarmPinOut));
    host_cpu_model host (.clk(clk), .hostReq(hostReq), .hostRdData(hostRdData));
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
        host.rd(a, rdVal);
        `CHK(what, e, rdVal)
    endtask : rd_chk
    // one-cycle framer pulse on a carrier bit
    task automatic pulse(input int pos);
        @(negedge clk);
        framerIn[pos] = 1'b1;
        @(negedge clk);
        framerIn[pos] = 1'b0;
    endtask : pulse
    task automatic ts16(input logic [7:0] b, input logic f0);
        @(negedge clk);
        framerIn.ts16Strobe = 1'b1;
        framerIn.ts16Frame0 = f0;
        framerIn.ts16Byte = b;
        @(negedge clk);
        framerIn.ts16Strobe = 1'b0;
    endtask : ts16
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    initial begin
        rdVal = 8'($urandom(6));
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        foreach (regs[i]) rd_chk(8'(regs[i]), 8'h00, "reset value");
        m4 = 8'($urandom);
        host.wr(8'h1b, 8'hff);
        host.wr(8'h1d, m4);
        host.wr(8'h1a, 8'h55); // read-only places must ignore this
        host.wr(8'h1c, 8'h55);
        rd_chk(8'h1b, 8'hff, "mask3");
        rd_chk(8'h1d, m4, "mask4");
        rd_chk(8'h1c, 8'h00, "events");
        // E1 first, so no earlier boundary can fake an all-zeros multiframe
        for (int md = 1; md >= 0; md--) begin
            framerIn.e1Mode = md[0];
            expEv = 0;
            foreach (epos[i]) begin
                pulse(epos[i]);
                expEv |= (1 << ebit[i]) & (md ? 'h7f : 'h94);
            end
            @(negedge clk);
            `CHK("irq", ((expEv & m4) != 0) ? 1'b0 : 1'b1, intReqN)
            rd_chk(8'h1c, 8'(expEv), "events");
            rd_chk(8'h1c, 8'h00, "events after read");
        end
        foreach (cpos[i]) for (int md = 0; md < 2; md++) begin
            ok = ((1 << cbit[i]) & (md ? 'h1f : 'hf8)) != 0;
            framerIn.e1Mode = md[0];
            framerIn[cpos[i]] = 1'b1;
            repeat (3) @(negedge clk);
            `CHK("irq on rise", !ok, intReqN)
            rd_chk(8'h1a, ok ? 8'(1 << cbit[i]) : 8'h00, "condition");
            framerIn[cpos[i]] = 1'b0;
            repeat (3) @(negedge clk);
            `CHK("irq on fall", !ok, intReqN)
            host.rd(8'h1a, rdVal);
            @(negedge clk);
            `CHK("irq after read", 1'b1, intReqN)
        end
        framerIn.e1Mode = 1'b1;
        // a frozen block must not latch an align pulse
        clkEn = 1'b0;
        pulse(5);
        clkEn = 1'b1;
        rd_chk(8'h1c, 8'h00, "frozen events");
        ts16(8'h40, 1'b1);
        rd_chk(8'h1a, 8'h00, "one alarm multiframe");
        ts16(8'h40, 1'b1);
        rd_chk(8'h1a, 8'h02, "distant alarm");
        ts16(8'h00, 1'b1);
        rd_chk(8'h1a, 8'h00, "distant alarm gone");
        repeat (32) ts16(8'hff, 1'b0);
        rd_chk(8'h1c, 8'h40, "all ones");
        repeat (32) ts16(8'h00, 1'b0);
        pulse(3);
        repeat (16) ts16(8'h00, 1'b0);
        pulse(3);
        rd_chk(8'h1c, 8'h24, "all zeros");
        host.wr(8'h70, 8'h01);
        pinRun = 1'b0;
        repeat (300) @(negedge clk);
        rd_chk(8'h1a, 8'h18, "clock loss");
        `CHK("alarm pin", 1'b1, alarmPinOut)
        pinRun = 1'b1;
        repeat (40) @(negedge clk);
        rd_chk(8'h1a, 8'h00, "clocks back");
        `CHK("alarm pin", 1'b0, alarmPinOut)
        host.wr(8'h70, 8'h00);
        framerIn.rxLossOfSync = 1'b1;
        @(negedge clk);
        `CHK("alarm pin", 1'b1, alarmPinOut)
        stop_test();
    end
    // hang guard, many times the expected run length
    initial begin
        #400000;
        num_errors++;
        stop_test();
    end
endmodule : tb_top
